// [logic/sep_addr_pkg.sv]
package sep_addr_pkg;

	// ----------------------------------------
	// Register map (byte addresses, bit 0 ignored)
	// ----------------------------------------
	localparam logic [31:0] PORT3_LATCH_ADDR = 32'hfffff006;
	localparam logic [31:0] PORT10_LATCH_ADDR = 32'hfffff014;
	localparam logic [31:0] PORT11_LATCH_ADDR = 32'hfffff016;
	localparam logic [31:0] PORT3_DIR_ADDR = 32'hfffff026;
	localparam logic [31:0] PORT10_DIR_ADDR = 32'hfffff034;
	localparam logic [31:0] PORT11_DIR_ADDR = 32'hfffff036;
	localparam logic [31:0] EXP_MODE_ADDR = 32'hfffff04c;
	localparam logic [31:0] SEP_SEL_ADDR = 32'hfffff068;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] PORT3_DIR_RST = 8'hff;
	localparam logic [7:0] PORT10_DIR_RST = 8'hff;
	localparam logic [7:0] PORT11_DIR_RST = 8'h1f;
	localparam logic [7:0] EXP_MODE_RST = 8'h00;
	localparam logic [2:0] SEP_SEL_RST = 3'h0;
	localparam logic [7:0] SEP_SEL_READ = 8'h00;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int SEP_SEL_W = 3;
	localparam logic [7:0] EXP_MODE_MASK = 8'h0f;
	localparam int PORT3_ADDR_LSB = 4;

	// Separate address output selection
	typedef enum logic [2:0] {
		SEL_PORT = 3'h0,
		SEL_RSVD = 3'h1,
		SEL_32B = 3'h2,
		SEL_512B = 3'h3,
		SEL_8K = 3'h4,
		SEL_16K = 3'h5,
		SEL_32K = 3'h6,
		SEL_64K = 3'h7
	} sep_sel_e;

	// One register access from the CPU side
	typedef struct packed {
		logic [31:0] addr;
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} reg_req_s;

	// Drive of one 8-bit port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} port_drive_s;

endpackage : sep_addr_pkg

// [logic/separate_address_output_mux.sv]
module separate_address_output_mux (
	input wire logic clk, // 40 MHz clock
	input wire logic reset, // Synchronous, active high
	input wire logic ce, // Clock enable
	input wire sep_addr_pkg::reg_req_s req, // CPU register access
	input wire logic [15:1] bus_addr, // Address from bus controller
	input wire logic emu_mode, // In-circuit emulation strap
	input wire logic [7:0] port3_pin_in, // Port 3 pin levels
	input wire logic [7:0] port10_pin_in, // Port 10 pin levels
	input wire logic [7:0] port11_pin_in, // Port 11 pin levels
	output sep_addr_pkg::port_drive_s port3_drv, // Port 3 out and enable
	output sep_addr_pkg::port_drive_s port10_drv, // Port 10 out and enable
	output sep_addr_pkg::port_drive_s port11_drv, // Port 11 out and enable
	output logic [7:0] rdata, // Read data, valid cycle after rd
	output logic sep_bus_active, // Separate address bus in use
	output logic wait_pin_enable // Pin wait input usable
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Address match with bit 0 not decoded
	function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
		hit = (a[31:1] == base[31:1]);
	endfunction : hit

	// Byte or single-bit write into an 8-bit register
	function automatic logic [7:0] apply_wr(input logic [7:0] old,
		input sep_addr_pkg::reg_req_s r);
		logic [7:0] v;
		v = old;
		if (r.bit_op) begin
			v[r.bit_idx] = r.wdata[0];
		end else begin
			v = r.wdata;
		end
		apply_wr = v;
	endfunction : apply_wr

	// Port read: pin level for inputs, latch for outputs
	function automatic logic [7:0] port_rd(input logic [7:0] latch,
		input logic [7:0] dir, input logic [7:0] pin);
		port_rd = (dir & pin) | (~dir & latch);
	endfunction : port_rd

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	// Pins and the emulation strap arrive unsynchronised
	logic [7:0] p3_s1_r, p3_s2_r, p10_s1_r, p10_s2_r, p11_s1_r, p11_s2_r;
	logic emu_s1_r, emu_s2_r;
	logic [7:0] p3_s1_nxt, p3_s2_nxt, p10_s1_nxt, p10_s2_nxt, p11_s1_nxt, p11_s2_nxt;
	logic emu_s1_nxt, emu_s2_nxt;

	// Two-flop chains; only the second stage is read,
	// so a metastable first stage never reaches logic
	always_comb begin
		p3_s1_nxt = port3_pin_in;
		p3_s2_nxt = p3_s1_r;
		p10_s1_nxt = port10_pin_in;
		p10_s2_nxt = p10_s1_r;
		p11_s1_nxt = port11_pin_in;
		p11_s2_nxt = p11_s1_r;
		emu_s1_nxt = emu_mode;
		emu_s2_nxt = emu_s1_r;
	end

	// Synchroniser stages
	always_ff @(posedge clk) begin
		if (reset) begin
			p3_s1_r <= 8'h00;
			p3_s2_r <= 8'h00;
			p10_s1_r <= 8'h00;
			p10_s2_r <= 8'h00;
			p11_s1_r <= 8'h00;
			p11_s2_r <= 8'h00;
			emu_s1_r <= 1'b0;
			emu_s2_r <= 1'b0;
		end else if (ce) begin
			p3_s1_r <= p3_s1_nxt;
			p3_s2_r <= p3_s2_nxt;
			p10_s1_r <= p10_s1_nxt;
			p10_s2_r <= p10_s2_nxt;
			p11_s1_r <= p11_s1_nxt;
			p11_s2_r <= p11_s2_nxt;
			emu_s1_r <= emu_s1_nxt;
			emu_s2_r <= emu_s2_nxt;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Register storage and next values
	logic [7:0] p3_lat_r, p10_lat_r, p11_lat_r, p3_dir_r, p10_dir_r, p11_dir_r, mm_r;
	logic [7:0] p3_lat_nxt, p10_lat_nxt, p11_lat_nxt;
	logic [7:0] p3_dir_nxt, p10_dir_nxt, p11_dir_nxt, mm_nxt;
	sep_addr_pkg::sep_sel_e sel_r, sel_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	// Write decode and read mux
	always_comb begin
		p3_lat_nxt = p3_lat_r;
		p10_lat_nxt = p10_lat_r;
		p11_lat_nxt = p11_lat_r;
		p3_dir_nxt = p3_dir_r;
		p10_dir_nxt = p10_dir_r;
		p11_dir_nxt = p11_dir_r;
		mm_nxt = mm_r;
		sel_nxt = sel_r;
		rdata_nxt = 8'h00;
		if (req.wr) begin
			// Output latches take byte or single-bit writes
			if (hit(req.addr, sep_addr_pkg::PORT3_LATCH_ADDR)) begin
				p3_lat_nxt = apply_wr(p3_lat_r, req);
			end
			if (hit(req.addr, sep_addr_pkg::PORT10_LATCH_ADDR)) begin
				p10_lat_nxt = apply_wr(p10_lat_r, req);
			end
			if (hit(req.addr, sep_addr_pkg::PORT11_LATCH_ADDR)) begin
				p11_lat_nxt = apply_wr(p11_lat_r, req);
			end
			// Direction bits: 1 keeps a pin an input
			if (hit(req.addr, sep_addr_pkg::PORT3_DIR_ADDR)) begin
				p3_dir_nxt = apply_wr(p3_dir_r, req);
			end
			if (hit(req.addr, sep_addr_pkg::PORT10_DIR_ADDR)) begin
				p10_dir_nxt = apply_wr(p10_dir_r, req);
			end
			if (hit(req.addr, sep_addr_pkg::PORT11_DIR_ADDR)) begin
				p11_dir_nxt = apply_wr(p11_dir_r, req);
			end
			// Upper nibble held at zero
			if (hit(req.addr, sep_addr_pkg::EXP_MODE_ADDR)) begin
				mm_nxt = apply_wr(mm_r, req) & sep_addr_pkg::EXP_MODE_MASK;
			end
			// Byte writes only; high bits dropped
			if (hit(req.addr, sep_addr_pkg::SEP_SEL_ADDR) && !req.bit_op) begin
				sel_nxt = sep_addr_pkg::sep_sel_e'(req.wdata[sep_addr_pkg::SEP_SEL_W-1:0]);
			end
		end
		// Read answer is registered; unmapped reads give zero
		if (req.rd) begin
			if (hit(req.addr, sep_addr_pkg::PORT3_LATCH_ADDR)) begin
				rdata_nxt = port_rd(p3_lat_r, p3_dir_r, p3_s2_r);
			end else if (hit(req.addr, sep_addr_pkg::PORT10_LATCH_ADDR)) begin
				rdata_nxt = port_rd(p10_lat_r, p10_dir_r, p10_s2_r);
			end else if (hit(req.addr, sep_addr_pkg::PORT11_LATCH_ADDR)) begin
				rdata_nxt = port_rd(p11_lat_r, p11_dir_r, p11_s2_r);
			end else if (hit(req.addr, sep_addr_pkg::PORT3_DIR_ADDR)) begin
				rdata_nxt = p3_dir_r;
			end else if (hit(req.addr, sep_addr_pkg::PORT10_DIR_ADDR)) begin
				rdata_nxt = p10_dir_r;
			end else if (hit(req.addr, sep_addr_pkg::PORT11_DIR_ADDR)) begin
				rdata_nxt = p11_dir_r;
			end else if (hit(req.addr, sep_addr_pkg::EXP_MODE_ADDR)) begin
				rdata_nxt = mm_r;
			end else if (hit(req.addr, sep_addr_pkg::SEP_SEL_ADDR)) begin
				rdata_nxt = sep_addr_pkg::SEP_SEL_READ;
			end
		end
	end

	// Register state; ce low freezes every field
	always_ff @(posedge clk) begin
		if (reset) begin
			p3_lat_r <= sep_addr_pkg::LATCH_RST;
			p10_lat_r <= sep_addr_pkg::LATCH_RST;
			p11_lat_r <= sep_addr_pkg::LATCH_RST;
			p3_dir_r <= sep_addr_pkg::PORT3_DIR_RST;
			p10_dir_r <= sep_addr_pkg::PORT10_DIR_RST;
			p11_dir_r <= sep_addr_pkg::PORT11_DIR_RST;
			mm_r <= sep_addr_pkg::EXP_MODE_RST;
			sel_r <= sep_addr_pkg::sep_sel_e'(sep_addr_pkg::SEP_SEL_RST);
			rdata_r <= 8'h00;
		end else if (ce) begin
			p3_lat_r <= p3_lat_nxt;
			p10_lat_r <= p10_lat_nxt;
			p11_lat_r <= p11_lat_nxt;
			p3_dir_r <= p3_dir_nxt;
			p10_dir_r <= p10_dir_nxt;
			p11_dir_r <= p11_dir_nxt;
			mm_r <= mm_nxt;
			sel_r <= sel_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Pin mux
	// ----------------------------------------
	// Pin mux working signals
	logic exp_on;
	logic [7:0] m3, m10, m11;
	sep_addr_pkg::port_drive_s d3_nxt, d10_nxt, d11_nxt, d3_r, d10_r, d11_r;
	logic act_nxt, act_r;

	// Expansion active for the five codes 3 to 7 in bits 2-0
	always_comb begin
		exp_on = (mm_r[2:0] == 3'h3) || mm_r[2];
		// Emulation strap keeps a software write from switching over
		act_nxt = exp_on && !emu_s2_r && (sel_r != sep_addr_pkg::SEL_PORT)
			&& (sel_r != sep_addr_pkg::SEL_RSVD);
		// Start with no pin taken over
		m3 = 8'h00;
		m10 = 8'h00;
		m11 = 8'h00;
		// Cumulative address ranges per selection code
		unique case (sel_r)
			sep_addr_pkg::SEL_PORT, sep_addr_pkg::SEL_RSVD: begin
				m11 = 8'h00;
			end
			sep_addr_pkg::SEL_32B: begin
				m11 = 8'h0f;
			end
			sep_addr_pkg::SEL_512B: begin
				m11 = 8'h0f;
				m10 = 8'h0f;
			end
			sep_addr_pkg::SEL_8K: begin
				m11 = 8'h0f;
				m10 = 8'hff;
			end
			sep_addr_pkg::SEL_16K: begin
				m11 = 8'h0f;
				m10 = 8'hff;
				m3 = 8'h10;
			end
			sep_addr_pkg::SEL_32K: begin
				m11 = 8'h0f;
				m10 = 8'hff;
				m3 = 8'h30;
			end
			sep_addr_pkg::SEL_64K: begin
				m11 = 8'h0f;
				m10 = 8'hff;
				m3 = 8'h70;
			end
		endcase
		// Without a live mode every pin stays a plain port
		if (!act_nxt) begin
			m3 = 8'h00;
			m10 = 8'h00;
			m11 = 8'h00;
		end
		// Address bits override latch on selected pins only
		// Port 11 low nibble carries A1-A4
		d11_nxt.out = (m11 & {4'h0, bus_addr[4:1]}) | (~m11 & p11_lat_r);
		d11_nxt.oe = m11 | ~p11_dir_r;
		// Port 10 carries A5-A12
		d10_nxt.out = (m10 & bus_addr[12:5]) | (~m10 & p10_lat_r);
		d10_nxt.oe = m10 | ~p10_dir_r;
		// Port 3 bits 4-6 carry A13-A15
		d3_nxt.out = (m3 & {1'b0, bus_addr[15:13], 4'h0}) | (~m3 & p3_lat_r);
		d3_nxt.oe = m3 | ~p3_dir_r;
	end

	// Pin drive registers feed the ports directly
	always_ff @(posedge clk) begin
		if (reset) begin
			d3_r <= '0;
			d10_r <= '0;
			d11_r <= '0;
			act_r <= 1'b0;
		end else if (ce) begin
			d3_r <= d3_nxt;
			d10_r <= d10_nxt;
			d11_r <= d11_nxt;
			act_r <= act_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output comes from a flip-flop; wait_pin_enable through an inverter on act_r
	assign port3_drv = d3_r;
	assign port10_drv = d10_r;
	assign port11_drv = d11_r;
	assign rdata = rdata_r;
	assign sep_bus_active = act_r;
	// A1 takes over the wait pin while separate mode runs
	assign wait_pin_enable = !act_r;

endmodule : separate_address_output_mux

// [sim/ext_mem_model.sv]
module ext_mem_model (
	input wire logic clk, // Bus clock
	input wire sep_addr_pkg::port_drive_s drv3, // Port 3 drive
	input wire sep_addr_pkg::port_drive_s drv10, // Port 10 drive
	input wire sep_addr_pkg::port_drive_s drv11, // Port 11 drive
	output logic [7:0] pin3, // Port 3 level
	output logic [7:0] pin10, // Port 10 level
	output logic [7:0] pin11, // Port 11 level
	output logic [15:1] seen_addr // Address as decoded
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------
	// Pins
	// ----------
	// Last level each pin was driven to
	logic [7:0] last3 = 8'h00;
	logic [7:0] last10 = 8'h00;
	logic [7:0] last11 = 8'h00;
	// Keep a bit's level only while the device drives it
	function automatic logic [7:0] keep(input logic [7:0] last,
		input sep_addr_pkg::port_drive_s d);
		logic [7:0] v;
		v = last;
		for (int i = 0; i < 8; i++) begin
			if (d.oe[i] === 1'b1) begin
				v[i] = d.out[i];
			end
		end
		return v;
	endfunction : keep
	// Only the device drives; undriven pins show the inverse of their last level
	assign pin3 = (drv3.oe & drv3.out) | (~drv3.oe & ~last3);
	assign pin10 = (drv10.oe & drv10.out) | (~drv10.oe & ~last10);
	assign pin11 = (drv11.oe & drv11.out) | (~drv11.oe & ~last11);
	always @(posedge clk) begin
		last3 <= keep(last3, drv3);
		last10 <= keep(last10, drv10);
		last11 <= keep(last11, drv11);
	end
	// Address taken only from lines the device drives
	assign seen_addr = {pin3[6:4], pin10, pin11[3:0]} & {drv3.oe[6:4], drv10.oe, drv11.oe[3:0]};
endmodule : ext_mem_model

// [sim/sep_addr_asserts.sv]
module sep_addr_asserts (
	input wire logic clk, // Clock
	input wire logic reset, // Sync reset
	input wire logic ce, // Clock enable
	input wire sep_addr_pkg::reg_req_s req, // Register access
	input wire logic [15:1] bus_addr, // Bus address
	input wire logic emu_mode, // Emulation strap
	input wire logic [7:0] port3_pin_in, // Port 3 pins
	input wire logic [7:0] port10_pin_in, // Port 10 pins
	input wire logic [7:0] port11_pin_in, // Port 11 pins
	input wire sep_addr_pkg::port_drive_s port3_drv, // Port 3 drive
	input wire sep_addr_pkg::port_drive_s port10_drv, // Port 10 drive
	input wire sep_addr_pkg::port_drive_s port11_drv, // Port 11 drive
	input wire logic [7:0] rdata, // Read data
	input wire logic sep_bus_active, // Separate bus on
	input wire logic wait_pin_enable // Wait pin usable
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------
	// Decode
	// ----------
	// Read strobes per target
	logic rd_sel, rd_exp, rd_far;
	assign rd_sel = ce && req.rd && req.addr[31:1] == sep_addr_pkg::SEP_SEL_ADDR[31:1];
	assign rd_exp = ce && req.rd && req.addr[31:1] == sep_addr_pkg::EXP_MODE_ADDR[31:1];
	assign rd_far = ce && req.rd && req.addr[31:8] != 24'hfffff0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------
	// Checks
	// ----------
	a_wait_pin_inverse: assert property (wait_pin_enable == !sep_bus_active)
		else $error("wait pin enable does not track separate bus");
	a_sel_read_zero: assert property (rd_sel |=> rdata == 8'h00)
		else $error("selection read returned data");
	a_unmapped_read: assert property (rd_far |=> rdata == 8'h00)
		else $error("unmapped read returned data");
	a_exp_high_zero: assert property (rd_exp |=> rdata[7:4] == 4'h0)
		else $error("expansion upper bits not zero");
	a_low_addr_out: assert property (sep_bus_active && $past(ce) |->
		port11_drv.oe[3:0] == 4'hf && port11_drv.out[3:0] == $past(bus_addr[4:1]))
		else $error("low address lines not driven");
	a_emu_keeps_off: assert property ((emu_mode && ce && !sep_bus_active)[*3] |=> !sep_bus_active)
		else $error("separate bus enabled under emulation");
	a_freeze_hold: assert property (!ce |=> $stable(sep_bus_active) && $stable(port10_drv) && $stable(rdata))
		else $error("state moved with clock enable low");
	a_reset_inputs: assert property ($fell(reset) |-> port10_drv.oe == 8'h00 && port3_drv.oe == 8'h00)
		else $error("ports not inputs after reset");
	c_sep_on: cover property ($rose(sep_bus_active));
	c_emu_write: cover property (emu_mode && ce && req.wr);
	c_freeze: cover property (!ce && sep_bus_active);
endmodule : sep_addr_asserts

bind separate_address_output_mux sep_addr_asserts u_chk (.clk(clk), .reset(reset), .ce(ce),
	.req(req), .bus_addr(bus_addr), .emu_mode(emu_mode), .port3_pin_in(port3_pin_in),
	.port10_pin_in(port10_pin_in), .port11_pin_in(port11_pin_in), .port3_drv(port3_drv),
	.port10_drv(port10_drv), .port11_drv(port11_drv), .rdata(rdata),
	.sep_bus_active(sep_bus_active), .wait_pin_enable(wait_pin_enable));

// [sim/separate_address_output_mux_tb_top.sv]
module separate_address_output_mux_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------
	// Signals
	// ----------
	logic clk = 1'b0;
	logic reset, ce, emu;
	sep_addr_pkg::reg_req_s req;
	sep_addr_pkg::port_drive_s drv3, drv10, drv11;
	logic [15:1] bus_addr, seen, hold;
	logic [7:0] pin3, pin10, pin11, dir3, dir10, dir11, rdata;
	logic sep_bus_active, wait_pin_enable;
	logic [31:0] rng = 32'h3abc;
	int fails = 0;
	int n_tests = 0;
	int ms, me;
	int nb[8] = '{0, 0, 4, 8, 12, 13, 14, 15};
`define chk(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s: expected %h seen %h", nm, e, g); end end
	always #12.5 clk = ~clk;
	separate_address_output_mux uut (.clk(clk), .reset(reset), .ce(ce), .req(req),
		.bus_addr(bus_addr), .emu_mode(emu), .port3_pin_in(pin3), .port10_pin_in(pin10),
		.port11_pin_in(pin11), .port3_drv(drv3), .port10_drv(drv10), .port11_drv(drv11),
		.rdata(rdata), .sep_bus_active(sep_bus_active), .wait_pin_enable(wait_pin_enable));
	ext_mem_model u_far (.clk(clk), .drv3(drv3), .drv10(drv10), .drv11(drv11),
		.pin3(pin3), .pin10(pin10), .pin11(pin11), .seen_addr(seen));
	// ----------
	// Tasks
	// ----------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	// One access; an idle edge first keeps strobes apart
	task automatic acc(input logic [31:0] a, input logic w, b, input logic [2:0] i,
		input logic [7:0] d);
		@(posedge clk);
		#2;
		req = '{a, w, !w, b, i, d};
		@(posedge clk);
		#2;
		req.wr = 1'b0;
		req.rd = 1'b0;
	endtask : acc
	task automatic rdc(input logic [31:0] a, input logic [7:0] e);
		acc(a, 1'b0, 1'b0, 3'h0, 8'h00);
		`chk("rdata", e, rdata)
	endtask : rdc
	// Random address, then pins against the model
	task automatic check();
		logic act;
		logic [14:0] m;
		rng = xs(rng);
		bus_addr = rng[14:0];
		act = ms >= 2 && (me[2:0] == 3'h3 || me[2]) && !emu;
		m = act ? 15'h7fff >> (15 - nb[ms]) : 15'h0;
		repeat (2) @(posedge clk);
		#2;
		`chk("sep_active", act, sep_bus_active)
		`chk("wait_pin", !act, wait_pin_enable)
		`chk("p11_oe", ~dir11 | {4'h0, m[3:0]}, drv11.oe)
		`chk("p10_oe", ~dir10 | m[11:4], drv10.oe)
		`chk("p3_oe", ~dir3 | {1'b0, m[14:12], 4'h0}, drv3.oe)
		`chk("seen_addr", bus_addr & m, seen)
	endtask : check
	task automatic setup(input int s, e);
		acc(sep_addr_pkg::SEP_SEL_ADDR, 1'b1, 1'b0, 3'h0, 8'(s) | 8'hf8);
		acc(sep_addr_pkg::EXP_MODE_ADDR, 1'b1, 1'b0, 3'h0, 8'(e));
		ms = s;
		me = e;
		check();
	endtask : setup
	// ----------
	// Sequence
	// ----------
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		emu = 1'b0;
		bus_addr = '0;
		req = '0;
		dir3 = 8'hff;
		dir10 = 8'hff;
		dir11 = 8'h1f;
		ms = 0;
		me = 0;
		repeat (5) @(posedge clk);
		#2;
		reset = 1'b0;
		rdc(sep_addr_pkg::PORT10_DIR_ADDR | 32'h1, 8'hff);
		rdc(sep_addr_pkg::PORT11_DIR_ADDR, 8'h1f);
		rdc(sep_addr_pkg::SEP_SEL_ADDR, 8'h00);
		rdc(32'h00001000, 8'h00);
		acc(sep_addr_pkg::EXP_MODE_ADDR, 1'b1, 1'b0, 3'h0, 8'hff);
		rdc(sep_addr_pkg::EXP_MODE_ADDR, 8'h0f);
		acc(sep_addr_pkg::EXP_MODE_ADDR, 1'b1, 1'b1, 3'h3, 8'h00);
		rdc(sep_addr_pkg::EXP_MODE_ADDR, 8'h07);
		for (int c = 0; c < 8; c++) begin
			setup(c, 3);
		end
		for (int e = 0; e < 8; e++) begin
			setup(7, e);
		end
		setup(0, 3);
		acc(sep_addr_pkg::SEP_SEL_ADDR, 1'b1, 1'b1, 3'h1, 8'h01);
		check();
		emu = 1'b1;
		repeat (4) @(posedge clk);
		setup(7, 3);
		emu = 1'b0;
		repeat (4) @(posedge clk);
		setup(7, 3);
		ce = 1'b0;
		hold = bus_addr;
		bus_addr = 15'h5555;
		repeat (3) @(posedge clk);
		#2;
		`chk("p10_frozen", hold[12:5], drv10.out)
		`chk("sep_frozen", 1'b1, sep_bus_active)
		ce = 1'b1;
		// Bring-up order: latches, directions, selection, expansion
		acc(sep_addr_pkg::PORT3_LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h00);
		acc(sep_addr_pkg::PORT10_LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h00);
		acc(sep_addr_pkg::PORT11_LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h00);
		acc(sep_addr_pkg::PORT3_DIR_ADDR, 1'b1, 1'b0, 3'h0, 8'h8f);
		acc(sep_addr_pkg::PORT10_DIR_ADDR, 1'b1, 1'b0, 3'h0, 8'h00);
		acc(sep_addr_pkg::PORT11_DIR_ADDR, 1'b1, 1'b0, 3'h0, 8'h10);
		dir3 = 8'h8f;
		dir10 = 8'h00;
		dir11 = 8'h10;
		setup(6, 3);
		rdc(sep_addr_pkg::PORT3_LATCH_ADDR, dir3 & pin3);
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		reset = 1'b0;
		ms = 0;
		me = 0;
		dir3 = 8'hff;
		dir10 = 8'hff;
		dir11 = 8'h1f;
		check();
		finish_test();
	end
	// Watchdog well past the expected run
	initial begin
		#100000;
		fails++;
		finish_test();
	end
endmodule : separate_address_output_mux_tb_top
